//--- core/sctl_pkg.sv
// Constants and types shared by the clock select and tune block
`default_nettype none
package sctl_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_TUNE = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_TMRA = 4'h8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TUNE_LFSRC  = 7;
	localparam int TUNE_MULT   = 6;
	localparam int TUNE_TRIMHI = 4;
	localparam int CTRL_IDLE   = 7;
	localparam int CTRL_IFSHI  = 6;
	localparam int CTRL_IFSLO  = 4;
	localparam int CTRL_PRIOK  = 3;
	localparam int CTRL_INTOK  = 2;
	localparam int CTRL_SELHI  = 1;
	localparam int TMRA_SECRUN = 6;
	localparam int TMRA_SECEN  = 3;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [7:0] TUNE_RST   = 8'h00;
	localparam logic [7:0] TMRA_RST   = 8'h00;
	localparam logic [2:0] IFS_RST    = 3'h4;
	localparam logic [1:0] SEL_RST    = 2'h0;
	localparam logic [2:0] IFS_8M     = 3'h7;
	localparam logic [2:0] IFS_4M     = 3'h6;
	localparam logic [2:0] IFS_LF     = 3'h0;
	localparam logic [3:0] CFG_INT_A  = 4'h9;
	localparam logic [3:0] CFG_INT_B  = 4'h8;
	localparam logic [1:0] SEL_SEC    = 2'h1;
	localparam logic [4:0] TRIM_FLIP  = 5'h10;
	localparam logic [2:0] OLD_TICKS  = 3'h2;
	localparam logic [2:0] NEW_TICKS  = 3'h3;

	// Synchroniser lanes
	localparam int SY_PRI = 0;
	localparam int SY_SEC = 1;
	localparam int SY_INT = 2;
	localparam int SY_PRDY = 3;
	localparam int SY_IRDY = 4;
	localparam int SY_NUM = 5;

	// Clock source, one-hot, bit index equals its lane
	typedef enum logic [2:0] {
		SRC_PRI = 3'b001,
		SRC_SEC = 3'b010,
		SRC_INT = 3'b100
	} sctl_src_t;

	// Switch sequencer states
	typedef enum logic [2:0] {
		SW_RUN = 3'b001,
		SW_OLD = 3'b010,
		SW_NEW = 3'b100
	} sctl_sw_t;
endpackage : sctl_pkg
`default_nettype wire

//--- core/sctl_sync3.sv
// Three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module sctl_sync3 (
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	input  wire logic i_async,
	output logic      o_level,
	output logic      o_rise
);
	logic s1;
	logic s2;
	logic s3;

	// Level moves only once stages two and three agree
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			o_level <= 1'b0;
			o_rise  <= 1'b0;
		end else begin
			s1      <= i_async;
			s2      <= s1;
			s3      <= s2;
			o_level <= (s2 == s3) ? s3 : o_level;
			o_rise  <= (s2 == s3) && s3 && !o_level;
		end
	end
endmodule : sctl_sync3
`default_nettype wire

//--- core/sctl_tick_cnt.sv
// Counts oscillator ticks up to a target during a source switch
`timescale 1ns/1ps
`default_nettype none
module sctl_tick_cnt (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	input  wire logic       i_clear,
	input  wire logic       i_tick,
	input  wire logic [2:0] i_target,
	output logic            o_done
);
	logic [2:0] cnt;

	assign o_done = (cnt >= i_target);

	// Saturates at the target, restarts on clear
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt <= 3'h0;
		end else if (i_clear) begin
			cnt <= 3'h0;
		end else if (i_tick && !o_done) begin
			cnt <= cnt + 3'h1;
		end
	end
endmodule : sctl_tick_cnt
`default_nettype wire

//--- core/sctl_clock_ctrl.sv
// Clock source select, internal oscillator tune and status
`timescale 1ns/1ps
`default_nettype none
module sctl_clock_ctrl (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	input  wire logic [3:0]  i_primary_osc_config,
	input  wire logic        i_prim_osc,
	input  wire logic        i_sec_osc,
	input  wire logic        i_int_osc,
	input  wire logic        i_prim_ready,
	input  wire logic        i_int_stable,
	input  wire logic        i_sleep_exec,
	output logic      [2:0]  o_sys_src,
	output logic             o_clk_hold,
	output logic      [2:0]  o_int_freq_sel,
	output logic             o_lf_from_fast,
	output logic             o_mult_enable,
	output logic      [4:0]  o_trim_code,
	output logic             o_wdt_slow_sel,
	output logic             o_sec_osc_enable,
	output logic             o_enter_idle,
	output logic             o_enter_sleep
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic                lfsrc;
	logic                mult_bit;
	logic [4:0]          trim;
	logic                idle;
	logic [2:0]          ifs;
	logic [1:0]          srcsel;
	logic [7:0]          tmra;
	logic [3:0]          cfg;
	logic                cfg_taken;
	logic                st_pri;
	logic                st_int;
	logic                st_sec;
	sctl_pkg::sctl_src_t cur_src;
	sctl_pkg::sctl_sw_t  sw_state;

	// ------------------------------------------------------------
	// Synchronised oscillator and ready inputs
	// ------------------------------------------------------------
	logic [sctl_pkg::SY_NUM-1:0] sy_in;
	logic [sctl_pkg::SY_NUM-1:0] sy_lvl;
	logic [sctl_pkg::SY_NUM-1:0] sy_rise;

	assign sy_in = {i_int_stable, i_prim_ready, i_int_osc, i_sec_osc, i_prim_osc};

	genvar g;
	generate
		for (g = 0; g < sctl_pkg::SY_NUM; g++) begin : g_sync
			sctl_sync3 u_sync (
				.i_core_clk (i_core_clk),
				.i_reset    (i_reset),
				.i_async    (sy_in[g]),
				.o_level    (sy_lvl[g]),
				.o_rise     (sy_rise[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire req      = i_read || i_write;
	wire acc      = req && !o_waitrequest;
	wire wr_acc   = acc && i_write && i_byteenable[0];
	wire sel_tune = (i_address == sctl_pkg::ADDR_TUNE);
	wire sel_ctrl = (i_address == sctl_pkg::ADDR_CTRL);
	wire sel_tmra = (i_address == sctl_pkg::ADDR_TMRA);
	wire [7:0] wd = i_writedata[7:0];
	wire [1:0] wd_sel = wd[sctl_pkg::CTRL_SELHI:0];
	wire sec_en   = tmra[sctl_pkg::TMRA_SECEN];

	// Multiplier only offered in internal oscillator modes
	wire mult_avail = (cfg == sctl_pkg::CFG_INT_A) || (cfg == sctl_pkg::CFG_INT_B);
	wire mult_rd    = mult_bit && mult_avail;
	wire fast_sel   = (ifs == sctl_pkg::IFS_8M) || (ifs == sctl_pkg::IFS_4M);
	wire next_mult  = mult_rd && fast_sel;

	// Secondary select refused while its oscillator is off
	wire sel_refuse = (wd_sel == sctl_pkg::SEL_SEC) && !sec_en;

	// Read data mux, unmapped words read zero
	wire [7:0] rd_tune = {lfsrc, mult_rd, 1'b0, trim};
	wire [7:0] rd_ctrl = {idle, ifs, st_pri, st_int, srcsel};
	wire [7:0] rd_tmra = {tmra[7], st_sec, tmra[5:0]};
	wire [7:0] rd_mux  = sel_tune ? rd_tune :
	                     sel_ctrl ? rd_ctrl :
	                     sel_tmra ? rd_tmra : 8'h00;

	// One wait cycle, then accept for one cycle
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_waitrequest <= 1'b1;
			o_readdata    <= 32'h0000_0000;
		end else begin
			o_waitrequest <= !(req && o_waitrequest);
			if (i_read && o_waitrequest) begin
				o_readdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	// Tuning register
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			lfsrc    <= sctl_pkg::TUNE_RST[sctl_pkg::TUNE_LFSRC];
			mult_bit <= sctl_pkg::TUNE_RST[sctl_pkg::TUNE_MULT];
			trim     <= sctl_pkg::TUNE_RST[sctl_pkg::TUNE_TRIMHI:0];
		end else if (wr_acc && sel_tune) begin
			lfsrc    <= wd[sctl_pkg::TUNE_LFSRC];
			mult_bit <= wd[sctl_pkg::TUNE_MULT];
			trim     <= wd[sctl_pkg::TUNE_TRIMHI:0];
		end
	end

	// Control register, status bits are read-only
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			idle   <= 1'b0;
			ifs    <= sctl_pkg::IFS_RST;
			srcsel <= sctl_pkg::SEL_RST;
		end else if (wr_acc && sel_ctrl) begin
			idle <= wd[sctl_pkg::CTRL_IDLE];
			ifs  <= wd[sctl_pkg::CTRL_IFSHI:sctl_pkg::CTRL_IFSLO];
			if (!sel_refuse) begin
				srcsel <= wd_sel;
			end
		end
	end

	// Timer control register, bit 6 is status
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			tmra <= sctl_pkg::TMRA_RST;
		end else if (wr_acc && sel_tmra) begin
			tmra <= wd;
		end
	end

	// Oscillator configuration caught once after reset release
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg       <= 4'h0;
			cfg_taken <= 1'b0;
		end else if (!cfg_taken) begin
			cfg       <= i_primary_osc_config;
			cfg_taken <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Source switch sequencer
	// ------------------------------------------------------------
	// Requested source from the select field
	sctl_pkg::sctl_src_t req_src;
	assign req_src = srcsel[1] ? sctl_pkg::SRC_INT :
	                 srcsel[0] ? sctl_pkg::SRC_SEC : sctl_pkg::SRC_PRI;

	wire       want_sw  = (sw_state == sctl_pkg::SW_RUN) && (req_src != cur_src);
	wire       in_old   = (sw_state == sctl_pkg::SW_OLD);
	wire       tick     = |(sy_rise[2:0] & cur_src);
	wire [2:0] target   = in_old ? sctl_pkg::OLD_TICKS : sctl_pkg::NEW_TICKS;
	wire       cnt_done;
	wire       cnt_clr  = want_sw || cnt_done;

	sctl_tick_cnt u_cnt (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_clear    (cnt_clr),
		.i_tick     (tick),
		.i_target   (target),
		.o_done     (cnt_done)
	);

	// Next state of the switch sequencer
	sctl_pkg::sctl_sw_t next_state;
	always_comb begin
		next_state = sw_state;
		case (sw_state)
			sctl_pkg::SW_RUN: begin
				if (want_sw) begin
					next_state = sctl_pkg::SW_OLD;
				end
			end
			sctl_pkg::SW_OLD: begin
				if (cnt_done) begin
					next_state = sctl_pkg::SW_NEW;
				end
			end
			sctl_pkg::SW_NEW: begin
				if (cnt_done) begin
					next_state = sctl_pkg::SW_RUN;
				end
			end
			default: begin
				next_state = sctl_pkg::SW_RUN;
			end
		endcase
	end

	// Clock held from the request until new source ticks three times
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			sw_state <= sctl_pkg::SW_RUN;
			cur_src  <= sctl_pkg::SRC_PRI;
		end else begin
			sw_state <= next_state;
			if (in_old && cnt_done) begin
				cur_src <= req_src;
			end
		end
	end

	// ------------------------------------------------------------
	// Status flags, primary and internal ones gated by synchronised ready levels
	// ------------------------------------------------------------
	wire running   = (sw_state == sctl_pkg::SW_RUN);
	wire lf_slow   = (ifs == sctl_pkg::IFS_LF) && !lfsrc;
	wire next_pri  = running && (cur_src == sctl_pkg::SRC_PRI) && sy_lvl[sctl_pkg::SY_PRDY];
	wire next_int  = running && (cur_src == sctl_pkg::SRC_INT) && !lf_slow &&
	                 sy_lvl[sctl_pkg::SY_IRDY];
	wire next_sec  = running && (cur_src == sctl_pkg::SRC_SEC);

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			st_pri <= 1'b0;
			st_int <= 1'b0;
			st_sec <= 1'b0;
		end else begin
			st_pri <= next_pri;
			st_int <= next_int;
			st_sec <= next_sec;
		end
	end

	// ------------------------------------------------------------
	// Clock steering outputs
	// ------------------------------------------------------------
	wire next_hold = want_sw || (sw_state != sctl_pkg::SW_RUN && !(next_state == sctl_pkg::SW_RUN));
	wire next_lf   = (ifs == sctl_pkg::IFS_LF) && lfsrc;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_sys_src        <= sctl_pkg::SRC_PRI;
			o_clk_hold       <= 1'b0;
			o_int_freq_sel   <= sctl_pkg::IFS_RST;
			o_lf_from_fast   <= 1'b0;
			o_mult_enable    <= 1'b0;
			o_trim_code      <= sctl_pkg::TRIM_FLIP;
			o_wdt_slow_sel   <= 1'b1;
			o_sec_osc_enable <= 1'b0;
		end else begin
			o_sys_src        <= next_state == sctl_pkg::SW_NEW ? req_src : cur_src;
			o_clk_hold       <= next_hold;
			o_int_freq_sel   <= ifs;
			o_lf_from_fast   <= next_lf;
			o_mult_enable    <= next_mult;
			o_trim_code      <= trim ^ sctl_pkg::TRIM_FLIP;
			o_wdt_slow_sel   <= 1'b1;
			o_sec_osc_enable <= sec_en;
		end
	end

	// Sleep instruction steered by the idle bit
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_enter_idle  <= 1'b0;
			o_enter_sleep <= 1'b0;
		end else begin
			o_enter_idle  <= i_sleep_exec && idle;
			o_enter_sleep <= i_sleep_exec && !idle;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence s_req_wait;
		req && o_waitrequest;
	endsequence
	sequence s_accept;
		!o_waitrequest;
	endsequence

	a_bus_answer: assert property (s_req_wait |=> s_accept)
		else $error("bus answer not within one cycle");
	a_idle_entry: assert property (i_sleep_exec && idle |=> o_enter_idle && !o_enter_sleep)
		else $error("idle entry wrong");
	a_sleep_entry: assert property (i_sleep_exec && !idle |=> o_enter_sleep && !o_enter_idle)
		else $error("sleep entry wrong");
	a_status_onehot: assert property ($onehot0({st_pri, st_int, st_sec}))
		else $error("more than one status flag");
	a_sec_refused: assert property (wr_acc && sel_ctrl && sel_refuse |=> $stable(srcsel))
		else $error("secondary select taken while disabled");
	a_mult_gate: assert property (o_mult_enable |-> $past(mult_avail && fast_sel))
		else $error("multiplier outside allowed modes");
	a_mult_read0: assert property (
		i_read && sel_tune && !mult_avail && o_waitrequest |=> !o_readdata[sctl_pkg::TUNE_MULT])
		else $error("multiplier bit read nonzero");
	a_hold_start: assert property (want_sw |=> o_clk_hold && sw_state == sctl_pkg::SW_OLD)
		else $error("switch pause missing");
	a_lf_source: assert property (ifs == sctl_pkg::IFS_LF && lfsrc |=> o_lf_from_fast)
		else $error("low frequency source wrong");
	a_sec_status: assert property (st_sec |-> o_sys_src == sctl_pkg::SRC_SEC)
		else $error("secondary flag without secondary clock");
endmodule : sctl_clock_ctrl
`default_nettype wire

//--- tb/sctl_clock_ctrl_tb.sv
// Self-checking bench for the clock select and tune block
`timescale 1ns/1ps
`default_nettype none
module sctl_clock_ctrl_tb;
	// ------------------------------------------------------------
	// Stimulus and observation signals
	// ------------------------------------------------------------
	logic        i_core_clk           = 1'b0;
	logic        i_reset              = 1'b1;
	logic [3:0]  i_address            = 4'h0;
	logic        i_read               = 1'b0;
	logic        i_write              = 1'b0;
	logic [31:0] i_writedata          = 32'h0;
	logic [3:0]  i_byteenable         = 4'h1;
	logic [3:0]  i_primary_osc_config = sctl_pkg::CFG_INT_A;
	logic        i_prim_ready         = 1'b1;
	logic        i_int_stable         = 1'b1;
	logic        i_sleep_exec         = 1'b0;
	logic [7:0]  osc_cnt              = 8'h00;
	logic [31:0] xs_state             = 32'h00000012;
	logic [31:0] rq[$];
	int          failures             = 0;
	int          comparisons          = 0;
	wire logic [31:0] o_readdata;
	wire logic        o_waitrequest;
	wire logic [2:0]  o_sys_src;
	wire logic        o_clk_hold;
	wire logic [2:0]  o_int_freq_sel;
	wire logic        o_lf_from_fast;
	wire logic        o_mult_enable;
	wire logic [4:0]  o_trim_code;
	wire logic        o_wdt_slow_sel;
	wire logic        o_sec_osc_enable;
	wire logic        o_enter_idle;
	wire logic        o_enter_sleep;
	wire logic        i_prim_osc = osc_cnt[2];
	wire logic        i_sec_osc  = osc_cnt[3];
	wire logic        i_int_osc  = ~osc_cnt[2];

	sctl_clock_ctrl dut (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_primary_osc_config(i_primary_osc_config),
		.i_prim_osc(i_prim_osc), .i_sec_osc(i_sec_osc), .i_int_osc(i_int_osc),
		.i_prim_ready(i_prim_ready), .i_int_stable(i_int_stable),
		.i_sleep_exec(i_sleep_exec), .o_sys_src(o_sys_src), .o_clk_hold(o_clk_hold),
		.o_int_freq_sel(o_int_freq_sel), .o_lf_from_fast(o_lf_from_fast),
		.o_mult_enable(o_mult_enable), .o_trim_code(o_trim_code),
		.o_wdt_slow_sel(o_wdt_slow_sel), .o_sec_osc_enable(o_sec_osc_enable),
		.o_enter_idle(o_enter_idle), .o_enter_sleep(o_enter_sleep)
	);

	// ------------------------------------------------------------
	// Clock and free-running oscillator waveforms
	// ------------------------------------------------------------
	always #12.5 i_core_clk = ~i_core_clk;
	// Oscillators kept high and low for at least four core cycles
	always @(posedge i_core_clk) begin
		osc_cnt <= osc_cnt + 8'h01;
	end

	// ------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] xs();
		xs_state = xs_state ^ (xs_state << 13);
		xs_state = xs_state ^ (xs_state >> 17);
		xs_state = xs_state ^ (xs_state << 5);
		return xs_state;
	endfunction : xs

	// Read results are matched against the oldest note at the accept edge
	always @(posedge i_core_clk) begin
		if (i_read && o_waitrequest === 1'b0 && rq.size() > 0) begin
			check("readdata", o_readdata, rq.pop_front());
		end
	end

	// ------------------------------------------------------------
	// Bus master tasks: request held until waitrequest is seen low
	// ------------------------------------------------------------
	task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d,
			input logic [3:0] be, input logic [7:0] exp);
		int n;
		@(posedge i_core_clk);
		if (rd) begin
			rq.push_back({24'h0, exp});
		end
		i_read <= rd;
		i_write <= !rd;
		i_address <= a;
		i_writedata <= {24'h0, d};
		i_byteenable <= be;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		i_read <= 1'b0;
		i_write <= 1'b0;
		if (n >= 50) begin
			failures++;
			final_report();
		end
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b0, a, d, 4'h1, 8'h00);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		bus(1'b1, a, 8'h00, 4'h1, exp);
	endtask : rd

	// Waits for the pause flag to reach a level, counting edges
	task automatic wait_hold(input logic lvl, output int n);
		n = 0;
		while (o_clk_hold !== lvl && n < 200) begin
			@(posedge i_core_clk);
			n++;
		end
		if (n >= 200) begin
			failures++;
			final_report();
		end
	endtask : wait_hold

	// Writes a new select, reads status mid-pause and checks the pause span
	task automatic do_switch(input logic [7:0] c, input logic [2:0] src, input int lo, input int hi);
		int n;
		int len;
		wr(sctl_pkg::ADDR_CTRL, c);
		wait_hold(1'b1, n);
		check("hold_start", 32'(n <= 3), 32'h1);
		rd(sctl_pkg::ADDR_CTRL, c & 8'hf3);
		wait_hold(1'b0, len);
		check("pause_len", 32'(len + 3 >= lo && len + 3 <= hi), 32'h1);
		check("sys_src", 32'(o_sys_src), 32'(src));
		repeat (6) @(posedge i_core_clk);
	endtask : do_switch

	task automatic sleep_chk(input logic idle);
		@(posedge i_core_clk);
		i_sleep_exec <= 1'b1;
		@(posedge i_core_clk);
		i_sleep_exec <= 1'b0;
		@(posedge i_core_clk);
		check("enter_idle", 32'(o_enter_idle), 32'(idle));
		check("enter_sleep", 32'(o_enter_sleep), 32'(!idle));
	endtask : sleep_chk

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [7:0]  tv [4];
		logic        cfg_ok;
		tv = '{8'h0f, 8'h10, 8'h00, 8'h00};
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		check("src_rst", 32'(o_sys_src), 32'(sctl_pkg::SRC_PRI));
		check("freq_rst", 32'(o_int_freq_sel), 32'(sctl_pkg::IFS_RST));
		check("trim_rst", 32'(o_trim_code), 32'h10);
		rd(sctl_pkg::ADDR_TUNE, 8'h00);
		rd(sctl_pkg::ADDR_CTRL, 8'h48);
		rd(sctl_pkg::ADDR_TMRA, 8'h00);
		// Unmapped place and a write with lane 0 disabled are both ignored
		wr(4'hc, 8'hff);
		rd(4'hc, 8'h00);
		bus(1'b0, sctl_pkg::ADDR_TUNE, 8'hff, 4'he, 8'h00);
		rd(sctl_pkg::ADDR_TUNE, 8'h00);
		// Trim boundaries and one random value, bit 5 never stored
		for (int k = 0; k < 4; k++) begin
			r = xs();
			if (k < 3) r[7:0] = tv[k];
			wr(sctl_pkg::ADDR_TUNE, r[7:0]);
			rd(sctl_pkg::ADDR_TUNE, {r[7:6], 1'b0, r[4:0]});
			check("trim_code", 32'(o_trim_code), 32'(r[4:0] ^ sctl_pkg::TRIM_FLIP));
			check("mult_en", 32'(o_mult_enable), 32'h0);
		end
		// Every frequency code with the multiplier requested
		wr(sctl_pkg::ADDR_TUNE, 8'hc0);
		for (int f = 0; f < 8; f++) begin
			wr(sctl_pkg::ADDR_CTRL, {1'b0, 3'(f), 4'h0});
			repeat (2) @(posedge i_core_clk);
			check("freq_sel", 32'(o_int_freq_sel), 32'(f));
			check("mult_en", 32'(o_mult_enable), 32'(f >= 6));
			check("lf_fast", 32'(o_lf_from_fast), 32'(f == 0));
			check("wdt_sel", 32'(o_wdt_slow_sel), 32'h1);
		end
		wr(sctl_pkg::ADDR_TUNE, 8'h80);
		repeat (2) @(posedge i_core_clk);
		check("mult_off", 32'(o_mult_enable), 32'h0);
		wr(sctl_pkg::ADDR_TUNE, 8'h40);
		wr(sctl_pkg::ADDR_CTRL, 8'h00);
		repeat (2) @(posedge i_core_clk);
		check("lf_rc", 32'(o_lf_from_fast), 32'h0);
		wr(sctl_pkg::ADDR_TUNE, 8'h00);
		// Secondary select refused while its oscillator is off
		wr(sctl_pkg::ADDR_CTRL, 8'h41);
		repeat (6) @(posedge i_core_clk);
		rd(sctl_pkg::ADDR_CTRL, 8'h48);
		check("sec_en", 32'(o_sec_osc_enable), 32'h0);
		// Sleep instruction steered by the idle bit
		sleep_chk(1'b0);
		wr(sctl_pkg::ADDR_CTRL, 8'hc0);
		sleep_chk(1'b1);
		// Secondary oscillator runs before it is selected
		wr(sctl_pkg::ADDR_TMRA, 8'h08);
		rd(sctl_pkg::ADDR_TMRA, 8'h08);
		check("sec_en", 32'(o_sec_osc_enable), 32'h1);
		do_switch(8'h41, sctl_pkg::SRC_SEC, 38, 74);
		rd(sctl_pkg::ADDR_TMRA, 8'h48);
		rd(sctl_pkg::ADDR_CTRL, 8'h41);
		do_switch(8'h73, sctl_pkg::SRC_INT, 30, 66);
		rd(sctl_pkg::ADDR_CTRL, 8'h77);
		do_switch(8'h70, sctl_pkg::SRC_PRI, 22, 50);
		rd(sctl_pkg::ADDR_CTRL, 8'h78);
		do_switch(8'h72, sctl_pkg::SRC_INT, 22, 50);
		// Internal block not yet stable, then slow RC at 31 kHz: no flag
		i_int_stable <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		rd(sctl_pkg::ADDR_CTRL, 8'h72);
		i_int_stable <= 1'b1;
		wr(sctl_pkg::ADDR_CTRL, 8'h02);
		repeat (6) @(posedge i_core_clk);
		rd(sctl_pkg::ADDR_CTRL, 8'h02);
		// Mid-run resets: no multiplier and primary not ready, then both
		for (int j = 0; j < 2; j++) begin
			cfg_ok = (j == 1);
			i_primary_osc_config <= cfg_ok ? sctl_pkg::CFG_INT_B : 4'h0;
			i_prim_ready <= cfg_ok;
			i_reset <= 1'b1;
			repeat (2) @(posedge i_core_clk);
			i_reset <= 1'b0;
			repeat (6) @(posedge i_core_clk);
			check("src_rst", 32'(o_sys_src), 32'(sctl_pkg::SRC_PRI));
			rd(sctl_pkg::ADDR_CTRL, {4'h4, cfg_ok, 3'h0});
			wr(sctl_pkg::ADDR_TUNE, 8'h4f);
			rd(sctl_pkg::ADDR_TUNE, {1'b0, cfg_ok, 6'h0f});
			wr(sctl_pkg::ADDR_CTRL, 8'h70);
			repeat (2) @(posedge i_core_clk);
			check("mult_cfg", 32'(o_mult_enable), 32'(cfg_ok));
		end
		final_report();
	end
endmodule : sctl_clock_ctrl_tb
`default_nettype wire
